// ---- logic/rio_consts.svh ----
// Constants for the radio I/O holding register bank.
// Assumes a single 40 MHz clock; included by bare name.
`ifndef RIO_CONSTS_SVH
`define RIO_CONSTS_SVH

// ==========================================================
// Register numbers
`define RIO_REG_DI_FIRST   16'h0001
`define RIO_REG_AI_FIRST   16'h0005
`define RIO_REG_IN_LAST    16'h0008
`define RIO_REG_DO_ONE     16'h01f5
`define RIO_REG_DO_TWO     16'h01f6
`define RIO_REG_UN_THREE   16'h01f7
`define RIO_REG_UN_FOUR    16'h01f8
`define RIO_REG_SP_THREE   16'h01f9
`define RIO_REG_SP_FOUR    16'h01fa

// ==========================================================
// Function and exception codes
`define RIO_FN_READ        8'h03
`define RIO_FN_WRITE_ONE   8'h06
`define RIO_FN_WRITE_MANY  8'h10
`define RIO_EXC_FUNC       8'h01
`define RIO_EXC_ADDR       8'h02
`define RIO_EXC_VALUE      8'h03

// ==========================================================
// Slave identifiers and transfer limits
`define RIO_ID_MIN         8'h0b
`define RIO_ID_MAX         8'h3c
`define RIO_MAX_REGS_900   8'h55
`define RIO_MAX_REGS_24    8'h25

// ==========================================================
// Factory defaults
`define RIO_DI_EN_RST      1'b1
`define RIO_AI_EN_RST      1'b1
`define RIO_AI_FULLSCALE   1'b1
`define RIO_AI_MAX_RST     16'h4e20
`define RIO_AI_MIN_RST     16'h0000
`define RIO_DO_EN_RST      1'b1
`define RIO_DO_FLASH_RST   1'b0
`define RIO_SP_VOLT_RST    16'h0000
`define RIO_SP_HOLD_RST    1'b0

// ==========================================================
// Timing
`define RIO_CLK_HZ         40000000
`define RIO_DI_SAMPLE_MS   40
`define RIO_AI_SAMPLE_MS   1000
`define RIO_CYC_PER_MS     (`RIO_CLK_HZ / 1000)

`endif

// ---- logic/rio_pkg.sv ----
// Types shared by the radio I/O register bank.
// Assumes the frame handler delivers one register beat per request.
package rio_pkg;

  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic [7:0]  slave_id;
    logic [15:0] reg_num;
    logic [7:0]  count;
    logic [15:0] wdata;
  } rio_req_type;

  typedef struct packed {
    logic        valid;
    logic        last;
    logic        exc;
    logic [7:0]  code;
    logic [15:0] data;
  } rio_resp_type;

  typedef enum logic [1:0] {
    RIO_IDLE,
    RIO_READ,
    RIO_WRITE
  } rio_state_type;

endpackage

// ---- logic/rio_sync.sv ----
// Two-flop synchroniser for pins entering the mclk domain.
// Assumes inputs are quasi-static levels.
`timescale 1ns/1ps
module rio_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// ---- logic/rio_tick.sv ----
// Divider giving a one-cycle enable every CYCLES clocks.
// Assumes CYCLES is at least two.
`timescale 1ns/1ps
module rio_tick #(
  parameter int CYCLES = 2
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Enable pulse
  output logic      tick
);

  logic [31:0] cnt_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= 32'h0000_0000;
      tick   <= 1'b0;
    end else if (cnt_ff == 32'(CYCLES - 1)) begin
      cnt_ff <= 32'h0000_0000;
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
      tick   <= 1'b0;
    end
  end

endmodule

// ---- logic/rio_regbank.sv ----
// Holding register bank for the radio node's local I/O.
// Assumes a frame handler on mclk presents decoded register beats and
// accepts one answer beat per cycle; pins arrive asynchronously.
`timescale 1ns/1ps
`include "rio_consts.svh"
module rio_regbank #(
  parameter int DI_TICK_CYCLES = `RIO_DI_SAMPLE_MS * `RIO_CYC_PER_MS,
  parameter int AI_TICK_CYCLES = `RIO_AI_SAMPLE_MS * `RIO_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  // Node configuration pins
  input  wire logic                  modbus_mode,
  input  wire logic                  band_is_24g,
  input  wire logic [7:0]            slave_id_dial,
  // Discrete input pins, low when active
  input  wire logic [3:0]            discrete_in_n,
  // Current input converter
  input  wire logic [47:0]           current_code,
  input  wire logic [3:0]            current_valid,
  // Register requests and answers
  input  wire rio_pkg::rio_req_type  req,
  output logic                       req_ready,
  output rio_pkg::rio_resp_type      resp,
  // Outputs
  output logic [1:0]                 discrete_out,
  output logic [1:0]                 supply_on
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] scale_current(input logic [11:0] c);
    scale_current = {c, c[11:8]};
  endfunction

  function automatic logic range_ok(input logic [15:0] first,
                                    input logic [7:0]  cnt);
    logic [15:0] last;
    last = first + {8'h00, cnt} - 16'h0001;
    range_ok = (last >= first) &&
               (((first >= `RIO_REG_DI_FIRST) &&
                 (last <= `RIO_REG_IN_LAST)) ||
                ((first >= `RIO_REG_DO_ONE) &&
                 (last <= `RIO_REG_SP_FOUR)));
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [9:0]  pins_s;
  logic        mode_s;
  logic        band_s;
  logic [7:0]  id_s;
  logic [3:0]  di_s;

  rio_sync #(.W(10)) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({modbus_mode, band_is_24g, slave_id_dial}),
    .sync_out (pins_s)
  );

  rio_sync #(.W(4)) u_di_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (~discrete_in_n),
    .sync_out (di_s)
  );

  assign mode_s = pins_s[9];
  assign band_s = pins_s[8];
  assign id_s   = pins_s[7:0];

  // ==========================================================
  // Sample rate enables
  logic di_tick;
  logic ai_tick;

  rio_tick #(.CYCLES(DI_TICK_CYCLES)) u_di_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (di_tick)
  );

  rio_tick #(.CYCLES(AI_TICK_CYCLES)) u_ai_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (ai_tick)
  );

  // ==========================================================
  // Input registers
  logic [3:0]  di_ff;
  logic [47:0] ai_raw_ff;
  logic [63:0] ai_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      di_ff <= 4'h0;
    end else if (di_tick && `RIO_DI_EN_RST) begin
      di_ff <= di_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ai_raw_ff <= 48'h0000_0000_0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (current_valid[i]) begin
          ai_raw_ff[i*12 +: 12] <= current_code[i*12 +: 12];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ai_ff <= 64'h0000_0000_0000_0000;
    end else if (ai_tick && `RIO_AI_EN_RST && `RIO_AI_FULLSCALE) begin
      for (int i = 0; i < 4; i++) begin
        ai_ff[i*16 +: 16] <= scale_current(ai_raw_ff[i*12 +: 12]);
      end
    end
  end

  // ==========================================================
  // Output registers
  logic [1:0]  do_ff;
  logic [15:0] supply_three_ff;
  logic [15:0] supply_four_ff;
  logic        wr_en;
  logic [15:0] wr_num;
  logic [15:0] wr_data;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      do_ff <= 2'h0;
    end else if (wr_en && (wr_data <= 16'h0001)) begin
      if (wr_num == `RIO_REG_DO_ONE) begin
        do_ff[0] <= wr_data[0];
      end
      if (wr_num == `RIO_REG_DO_TWO) begin
        do_ff[1] <= wr_data[0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      supply_three_ff <= `RIO_SP_VOLT_RST;
      supply_four_ff  <= `RIO_SP_VOLT_RST;
    end else if (wr_en) begin
      if (wr_num == `RIO_REG_SP_THREE) begin
        supply_three_ff <= wr_data;
      end
      if (wr_num == `RIO_REG_SP_FOUR) begin
        supply_four_ff <= wr_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      discrete_out <= 2'h0;
      supply_on    <= 2'h0;
    end else begin
      discrete_out <= do_ff & {2{`RIO_DO_EN_RST}};
      supply_on    <= {|supply_four_ff, |supply_three_ff};
    end
  end

  // Reads: inputs per I/O number, outputs per output number
  function automatic logic [15:0] reg_read(input logic [15:0] n);
    reg_read = 16'h0000;
    if (n >= `RIO_REG_DI_FIRST && n < `RIO_REG_AI_FIRST) begin
      reg_read = {15'h0000, di_ff[2'(n - `RIO_REG_DI_FIRST)]};
    end else if (n >= `RIO_REG_AI_FIRST && n <= `RIO_REG_IN_LAST) begin
      reg_read = ai_ff[6'(n - `RIO_REG_AI_FIRST) * 16 +: 16];
    end else if (n == `RIO_REG_DO_ONE) begin
      reg_read = {15'h0000, do_ff[0]};
    end else if (n == `RIO_REG_DO_TWO) begin
      reg_read = {15'h0000, do_ff[1]};
    end else if (n == `RIO_REG_SP_THREE) begin
      reg_read = supply_three_ff;
    end else if (n == `RIO_REG_SP_FOUR) begin
      reg_read = supply_four_ff;
    end
  endfunction

  // ==========================================================
  // Request sequencer
  rio_pkg::rio_state_type state_ff;
  rio_pkg::rio_state_type nxt_state;
  logic [15:0]            ptr_ff;
  logic [15:0]            nxt_ptr;
  logic [7:0]             left_ff;
  logic [7:0]             nxt_left;
  rio_pkg::rio_resp_type  nxt_resp;
  logic                   addressed;
  logic [7:0]             limit;

  assign limit = band_s ? `RIO_MAX_REGS_24 : `RIO_MAX_REGS_900;
  assign addressed = mode_s && (id_s >= `RIO_ID_MIN) &&
                     (id_s <= `RIO_ID_MAX) && (req.slave_id == id_s);

  always_comb begin
    nxt_state = state_ff;
    nxt_ptr   = ptr_ff;
    nxt_left  = left_ff;
    nxt_resp  = '0;
    wr_en     = 1'b0;
    wr_num    = ptr_ff;
    wr_data   = req.wdata;
    unique case (state_ff)
      rio_pkg::RIO_IDLE: begin
        if (req.valid && addressed) begin
          nxt_resp.valid = 1'b1;
          nxt_resp.last  = 1'b1;
          nxt_resp.exc   = 1'b1;
          nxt_resp.data  = req.wdata;
          if (req.func == `RIO_FN_WRITE_ONE) begin
            if (!range_ok(req.reg_num, 8'h01)) begin
              nxt_resp.code = `RIO_EXC_ADDR;
            end else begin
              nxt_resp.exc = 1'b0;
              wr_en        = 1'b1;
              wr_num       = req.reg_num;
            end
          end else if (req.func == `RIO_FN_READ ||
                       req.func == `RIO_FN_WRITE_MANY) begin
            if (req.count == 8'h00 || req.count > limit) begin
              nxt_resp.code = `RIO_EXC_VALUE;
            end else if (!range_ok(req.reg_num, req.count)) begin
              nxt_resp.code = `RIO_EXC_ADDR;
            end else if (req.func == `RIO_FN_READ) begin
              nxt_resp  = '0;
              nxt_state = rio_pkg::RIO_READ;
              nxt_ptr   = req.reg_num;
              nxt_left  = req.count;
            end else begin
              wr_en    = 1'b1;
              wr_num   = req.reg_num;
              nxt_ptr  = req.reg_num + 16'h0001;
              nxt_left = req.count - 8'h01;
              if (req.count == 8'h01) begin
                nxt_resp.exc = 1'b0;
              end else begin
                nxt_resp  = '0;
                nxt_state = rio_pkg::RIO_WRITE;
              end
            end
          end else begin
            nxt_resp.code = `RIO_EXC_FUNC;
          end
        end
      end
      rio_pkg::RIO_READ: begin
        nxt_resp.valid = 1'b1;
        nxt_resp.data  = reg_read(ptr_ff);
        nxt_resp.last  = (left_ff == 8'h01);
        nxt_ptr        = ptr_ff + 16'h0001;
        nxt_left       = left_ff - 8'h01;
        if (left_ff == 8'h01) begin
          nxt_state = rio_pkg::RIO_IDLE;
        end
      end
      rio_pkg::RIO_WRITE: begin
        if (req.valid) begin
          wr_en    = 1'b1;
          nxt_ptr  = ptr_ff + 16'h0001;
          nxt_left = left_ff - 8'h01;
          if (left_ff == 8'h01) begin
            nxt_resp.valid = 1'b1;
            nxt_resp.last  = 1'b1;
            nxt_resp.data  = req.wdata;
            nxt_state      = rio_pkg::RIO_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff  <= rio_pkg::RIO_IDLE;
      ptr_ff    <= 16'h0000;
      left_ff   <= 8'h00;
      resp      <= '0;
      req_ready <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ptr_ff    <= nxt_ptr;
      left_ff   <= nxt_left;
      resp      <= nxt_resp;
      req_ready <= (nxt_state != rio_pkg::RIO_READ);
    end
  end

endmodule

// ---- tb/rio_regbank_props.sv ----
// Port checker for the radio I/O holding register bank.
// Bound to rio_regbank; pins are assumed quasi-static levels.
`timescale 1ns/1ps
module rio_regbank_props (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // Node pins
  input wire logic                  modbus_mode,
  input wire logic                  band_is_24g,
  input wire logic [7:0]            slave_id_dial,
  // Register port and outputs
  input wire rio_pkg::rio_req_type  req,
  input wire logic                  req_ready,
  input wire rio_pkg::rio_resp_type resp,
  input wire logic [1:0]            discrete_out,
  input wire logic [1:0]            supply_on
);
  logic [3:0]  pin_h;
  logic [15:0] dial_h;
  logic        settled;
  logic        take;
  logic        in_map;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Pins steady long enough to have crossed the synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_h  <= 4'h0;
      dial_h <= 16'h0;
    end else begin
      pin_h  <= {pin_h[1:0], band_is_24g, modbus_mode};
      dial_h <= {dial_h[7:0], slave_id_dial};
    end
  end
  assign settled = modbus_mode && pin_h == {2{band_is_24g, 1'b1}}
                   && dial_h == {2{slave_id_dial}}
                   && slave_id_dial >= 8'h0b && slave_id_dial <= 8'h3c;
  assign take = req.valid && req_ready && settled
                && req.slave_id == slave_id_dial;
  assign in_map = (req.reg_num >= 16'h0001 && req.reg_num <= 16'h0008)
                  || (req.reg_num >= 16'h01f5 && req.reg_num <= 16'h01fa);

  // ==========================================================
  // Assertions
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !resp.valid && !req_ready && discrete_out == 2'h0
    && supply_on == 2'h0)
    else $error("outputs active after reset");
  a_transparent_silent: assert property (
    (!modbus_mode && req_ready) [*6] |-> !resp.valid)
    else $error("answer given in transparent mode");
  a_local_id_silent: assert property (
    (req_ready && slave_id_dial < 8'h0b) [*6] |-> !resp.valid)
    else $error("answer given with local slave id");
  a_write_ack: assert property (
    take && req.func == 8'h06 && in_map |=> resp.valid && resp.last
    && !resp.exc && resp.data == $past(req.wdata))
    else $error("single write not echoed");
  a_out_drive: assert property (
    take && req.func == 8'h06 && req.reg_num == 16'h01f5
    && req.wdata <= 16'h0001 |-> ##2 discrete_out[0] == $past(req.wdata[0], 2))
    else $error("discrete output one not driven");
  a_supply_drive: assert property (
    take && req.func == 8'h06 && req.reg_num == 16'h01fa
    |-> ##2 supply_on[1] == ($past(req.wdata, 2) != 16'h0))
    else $error("supply four not driven");
  a_bad_func: assert property (
    take && !(req.func inside {8'h03, 8'h06, 8'h10})
    |=> resp.valid && resp.exc && resp.code == 8'h01)
    else $error("unknown function not refused");
  a_bad_count: assert property (
    take && req.func == 8'h03 && (req.count == 8'h00
    || req.count > (band_is_24g ? 8'h25 : 8'h55))
    |=> resp.valid && resp.exc && resp.code == 8'h03)
    else $error("bad count not refused");
  a_bad_addr: assert property (
    take && req.func == 8'h03 && req.count == 8'h01
    && req.reg_num > 16'h0008 && req.reg_num < 16'h01f5
    |=> resp.valid && resp.exc && resp.code == 8'h02)
    else $error("gap address not refused");
  a_read_latency: assert property (
    take && req.func == 8'h03 && req.reg_num == 16'h0001
    && req.count == 8'h01 |=> !resp.valid && !req_ready ##1 (resp.valid
    && resp.last && req_ready && !resp.exc && resp.data[15:1] == 15'h0))
    else $error("discrete read late or wide");
endmodule

bind rio_regbank rio_regbank_props rio_regbank_props_inst (
  .mclk(mclk), .sys_rst(sys_rst), .modbus_mode(modbus_mode),
  .band_is_24g(band_is_24g), .slave_id_dial(slave_id_dial), .req(req),
  .req_ready(req_ready), .resp(resp), .discrete_out(discrete_out),
  .supply_on(supply_on));

// ---- tb/rio_host.sv ----
// Modbus master model driving the register port beat by beat.
// Assumes the bench calls xfer and reads got, exc, code and rd_q.
`timescale 1ns/1ps
module rio_host (
  // Clock
  input  wire logic                  mclk,
  // Answers
  input  wire logic                  req_ready,
  input  wire rio_pkg::rio_resp_type resp,
  // Requests
  output rio_pkg::rio_req_type       req
);
  logic [15:0] rd_q[$];
  logic        got;
  logic        exc;
  logic [7:0]  code;

  initial req = '0;

  // ==========================================================
  // One transaction; write-many sends a ramp from wd
  task automatic xfer(input logic [7:0] fn, input logic [7:0] id,
                      input logic [15:0] rn, input logic [7:0] cnt,
                      input logic [15:0] wd);
    rio_pkg::rio_req_type beat;
    int n;
    n = (fn == 8'h10) ? int'(cnt) : 1;
    rd_q.delete();
    got = 1'b0;
    exc = 1'b0;
    code = 8'h00;
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      beat = '{1'b1, fn, id, rn + 16'(i), cnt, wd + 16'(i)};
      req <= beat;
      do @(posedge mclk); while (req_ready !== 1'b1);
    end
    // Released lines show the inverse of their last value
    beat = ~req;
    beat.valid = 1'b0;
    req <= beat;
    for (int w = 0; w < 120; w++) begin
      @(posedge mclk);
      if (resp.valid === 1'b1) begin
        got = 1'b1;
        exc = resp.exc;
        code = resp.code;
        rd_q.push_back(resp.data);
        if (resp.last === 1'b1) break;
      end
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the radio I/O holding register bank.
// Assumes rio_host as the master; short sampling ticks in simulation.
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [7:0] fn; logic [15:0] rn; logic [7:0] cnt; logic [15:0] wd;
    logic exc; logic [7:0] code; logic [15:0] d0; logic [3:0] outs;
  } rio_row_type;
  logic                  mclk;
  logic                  sys_rst;
  logic                  modbus_mode;
  logic                  band_is_24g;
  logic [7:0]            slave_id_dial;
  logic [3:0]            discrete_in_n;
  logic [47:0]           current_code;
  logic [3:0]            current_valid;
  rio_pkg::rio_req_type  req;
  logic                  req_ready;
  rio_pkg::rio_resp_type resp;
  logic [1:0]            discrete_out;
  logic [1:0]            supply_on;
  int                    err_total;
  int                    num_checks;
  rio_row_type           rows[20];
  logic [15:0]           exp_in[8];
  logic [15:0]           exp_out[6];

  rio_regbank #(.DI_TICK_CYCLES(8), .AI_TICK_CYCLES(16)) rio_regbank_inst (
    .mclk(mclk), .sys_rst(sys_rst), .modbus_mode(modbus_mode),
    .band_is_24g(band_is_24g), .slave_id_dial(slave_id_dial),
    .discrete_in_n(discrete_in_n), .current_code(current_code),
    .current_valid(current_valid), .req(req), .req_ready(req_ready),
    .resp(resp), .discrete_out(discrete_out), .supply_on(supply_on));
  rio_host rio_host_inst (.mclk(mclk), .req_ready(req_ready),
    .resp(resp), .req(req));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ==========================================================
  // Shared helpers
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic xf(input logic [7:0] fn, input logic [15:0] rn,
                    input logic [7:0] cnt, input logic [15:0] wd,
                    input logic [7:0] id);
    rio_host_inst.xfer(fn, id, rn, cnt, wd);
  endtask
  task automatic pins(input logic mm, input logic bd, input logic [7:0] id);
    @(posedge mclk);
    modbus_mode <= mm;
    band_is_24g <= bd;
    slave_id_dial <= id;
    repeat (5) @(posedge mclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{8'h03, 16'h1, 8'h1, 16'h0, 1'b0, 8'h0, 16'h1, 4'h0},
      '{8'h03, 16'h2, 8'h1, 16'h0, 1'b0, 8'h0, 16'h0, 4'h0},
      '{8'h03, 16'h5, 8'h1, 16'h0, 1'b0, 8'h0, 16'h0, 4'h0},
      '{8'h03, 16'h6, 8'h1, 16'h0, 1'b0, 8'h0, 16'hffff, 4'h0},
      '{8'h03, 16'h8, 8'h1, 16'h0, 1'b0, 8'h0, 16'h1231, 4'h0},
      '{8'h06, 16'h1f5, 8'h1, 16'h1, 1'b0, 8'h0, 16'h1, 4'h4},
      '{8'h06, 16'h1f6, 8'h1, 16'h1, 1'b0, 8'h0, 16'h1, 4'hc},
      '{8'h06, 16'h1f5, 8'h1, 16'h0, 1'b0, 8'h0, 16'h0, 4'h8},
      '{8'h06, 16'h1f9, 8'h1, 16'h7, 1'b0, 8'h0, 16'h7, 4'h9},
      '{8'h06, 16'h1fa, 8'h1, 16'h1, 1'b0, 8'h0, 16'h1, 4'hb},
      '{8'h06, 16'h1f7, 8'h1, 16'h5, 1'b0, 8'h0, 16'h5, 4'hb},
      '{8'h06, 16'h1, 8'h1, 16'h0, 1'b0, 8'h0, 16'h0, 4'hb},
      '{8'h03, 16'h1f7, 8'h1, 16'h0, 1'b0, 8'h0, 16'h0, 4'hb},
      '{8'h04, 16'h1, 8'h1, 16'h0, 1'b1, 8'h1, 16'h0, 4'hb},
      '{8'h03, 16'h9, 8'h1, 16'h0, 1'b1, 8'h2, 16'h0, 4'hb},
      '{8'h03, 16'h1, 8'h0, 16'h0, 1'b1, 8'h3, 16'h0, 4'hb},
      '{8'h03, 16'h1, 8'h56, 16'h0, 1'b1, 8'h3, 16'h0, 4'hb},
      '{8'h03, 16'h1, 8'h55, 16'h0, 1'b1, 8'h2, 16'h0, 4'hb},
      '{8'h03, 16'hfff0, 8'h20, 16'h0, 1'b1, 8'h2, 16'h0, 4'hb},
      '{8'h10, 16'h1f5, 8'h2, 16'h1, 1'b0, 8'h0, 16'h0, 4'hf}};
    exp_in = '{16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'hffff, 16'h8008,
               16'h1231};
    exp_out = '{16'h1, 16'h1, 16'h0, 16'h0, 16'h7, 16'h1};
    err_total = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    modbus_mode = 1'b1;
    band_is_24g = 1'b0;
    slave_id_dial = 8'h0b;
    discrete_in_n = 4'b1010;
    current_code = {12'h123, 12'h800, 12'hfff, 12'h000};
    current_valid = 4'h0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    current_valid <= 4'hf;
    @(posedge mclk);
    current_valid <= 4'h0;
    repeat (40) @(posedge mclk);
    foreach (rows[i]) begin
      xf(rows[i].fn, rows[i].rn, rows[i].cnt, rows[i].wd, 8'h0b);
      check(rio_host_inst.got === 1'b1 && rio_host_inst.exc === rows[i].exc
        && (!rows[i].exc || rio_host_inst.code === rows[i].code),
        "answer kind");
      if (rows[i].fn != 8'h10 && !rows[i].exc)
        check(rio_host_inst.rd_q[0] === rows[i].d0, "word");
      @(posedge mclk);
      check({discrete_out, supply_on} === rows[i].outs, "outs");
    end
    xf(8'h03, 16'h1, 8'h8, 16'h0, 8'h0b);
    check(rio_host_inst.rd_q.size() == 8, "input burst length");
    foreach (exp_in[i])
      check(rio_host_inst.rd_q[i] === exp_in[i], "input burst");
    xf(8'h03, 16'h1f5, 8'h6, 16'h0, 8'h0b);
    foreach (exp_out[i])
      check(rio_host_inst.rd_q[i] === exp_out[i], "output burst");
    xf(8'h03, 16'h1, 8'h1, 16'h0, 8'h0c);
    check(rio_host_inst.got === 1'b0, "foreign id answered");
    pins(1'b1, 1'b0, 8'h3c);
    xf(8'h03, 16'h1, 8'h1, 16'h0, 8'h3c);
    check(rio_host_inst.got === 1'b1, "top id ignored");
    pins(1'b1, 1'b0, 8'h0a);
    xf(8'h03, 16'h1, 8'h1, 16'h0, 8'h0a);
    check(rio_host_inst.got === 1'b0, "local id answered");
    pins(1'b1, 1'b1, 8'h0b);
    xf(8'h03, 16'h1, 8'h26, 16'h0, 8'h0b);
    check(rio_host_inst.code === 8'h03, "short band limit");
    xf(8'h03, 16'h1, 8'h25, 16'h0, 8'h0b);
    check(rio_host_inst.code === 8'h02, "short band edge");
    pins(1'b0, 1'b0, 8'h0b);
    xf(8'h06, 16'h1f5, 8'h1, 16'h0, 8'h0b);
    check(rio_host_inst.got === 1'b0, "transparent answered");
    check(discrete_out === 2'h3, "transparent write took");
    pins(1'b1, 1'b0, 8'h0b);
    discrete_in_n <= 4'b0101;
    repeat (20) @(posedge mclk);
    xf(8'h03, 16'h2, 8'h1, 16'h0, 8'h0b);
    check(rio_host_inst.rd_q[0] === 16'h1, "input not resampled");
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    check({discrete_out, supply_on} === 4'h0, "reset outs");
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    xf(8'h03, 16'h1f5, 8'h6, 16'h0, 8'h0b);
    foreach (exp_out[i])
      check(rio_host_inst.rd_q[i] === 16'h0, "default out");
    end_of_test();
  end
endmodule
